// ### dram_init_ctrl.sv
// host side power-up sequencer and command driver for a separate-I/O DRAM
`timescale 1ns/1ps
`include "init_seq_map.svh"
module dram_init_ctrl
  import init_seq_pkg::*;
#(
  parameter logic [`STABLE_CYC_W-1:0] STABLE_CYC =
    `STABLE_CYC_W'(`STABLE_CMD_CYC)
)(
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  input  wire logic [`MODE_W-1:0]   modeSetting,
  input  wire logic                 userReq,
  input  wire logic [1:0]           userOp,
  input  wire logic [`ADDR_W-1:0]   userAddr,
  input  wire logic [`BANK_W-1:0]   userBank,
  output logic                      userReady,
  output logic                      initDone,
  output logic                      cmdClk,
  output logic                      cmdClkN,
  output logic                      selectN,
  output logic                      writeEnN,
  output logic                      refreshN,
  output logic [`ADDR_W-1:0]        addr,
  output logic [`BANK_W-1:0]        bank
);

  typedef struct packed {
    logic                     ck;
    logic                     ckN;
    state_t                   st;
    logic [`STABLE_CYC_W-1:0] cnt;
    logic                     selN;
    logic                     weN;
    logic                     refN;
    logic [`ADDR_W-1:0]       addr;
    logic [`BANK_W-1:0]       bank;
    logic                     done;
  } regs_t;

  regs_t r;
  regs_t next_r;
  logic  rstMeta;
  logic  rstSync;
  logic  tick;
  logic  take;

  // pin levels {select, write enable, refresh}, all active low
  function automatic logic [2:0] pins(input cmd_t c);
    case (c)
      CMD_LOAD:    pins = 3'h0;
      CMD_REFRESH: pins = 3'h2;
      CMD_READ:    pins = 3'h3;
      CMD_WRITE:   pins = 3'h1;
      default:     pins = 3'h7;
    endcase
  endfunction

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // commands change as the command clock falls, centred on its rise
  assign tick = r.ck;
  // requests are refused until the whole sequence has run
  assign userReady = r.done && tick;
  assign take = userReq && userReady;

  always_comb
  begin
    next_r = r;
    // free-running divider, never gated or retuned
    next_r.ck = ~r.ck;
    next_r.ckN = r.ck;
    if (tick)
    begin
      {next_r.selN, next_r.weN, next_r.refN} = pins(CMD_NOP);
      next_r.addr = '0;
      next_r.bank = '0;
      case (r.st)
        ST_STABLE:
        begin
          next_r.cnt = r.cnt + `CNT_ONE;
          if (r.cnt >= STABLE_CYC - `CNT_ONE)
          begin
            next_r.st = ST_DUMMY;
            next_r.cnt = `CNT_ZERO;
          end
        end
        ST_DUMMY:
        begin
          // dummy loads carry an all-zero address
          {next_r.selN, next_r.weN, next_r.refN} = pins(CMD_LOAD);
          next_r.cnt = r.cnt + `CNT_ONE;
          if (r.cnt == `DUMMY_LOADS - `CNT_ONE)
            next_r.st = ST_VALID;
        end
        ST_VALID:
        begin
          {next_r.selN, next_r.weN, next_r.refN} = pins(CMD_LOAD);
          // only the low mode bits are ever driven
          next_r.addr = {{(`ADDR_W - `MODE_W){1'b0}}, modeSetting};
          next_r.st = ST_SETTLE;
          next_r.cnt = `CNT_ZERO;
        end
        ST_SETTLE:
        begin
          next_r.cnt = r.cnt + `CNT_ONE;
          if (r.cnt == `SETTLE_CYC - `CNT_ONE)
          begin
            next_r.st = ST_REFRESH;
            next_r.cnt = `CNT_ZERO;
          end
        end
        ST_REFRESH:
        begin
          // all bank refreshes first as one posted group, then the
          // no-operations, which cover every row cycle setting
          next_r.cnt = r.cnt + `CNT_ONE;
          if (r.cnt < `BANK_COUNT)
          begin
            {next_r.selN, next_r.weN, next_r.refN} =
              pins(CMD_REFRESH);
            next_r.bank = r.cnt[`BANK_W-1:0];
          end
          if (r.cnt == `BANK_COUNT + `REFRESH_NOPS - `CNT_ONE)
          begin
            next_r.st = ST_READY;
            next_r.done = 1'b1;
          end
        end
        ST_READY:
        begin
          if (take)
          begin
            case (op_t'(userOp))
              OP_READ:
                {next_r.selN, next_r.weN, next_r.refN} = pins(CMD_READ);
              OP_WRITE:
                {next_r.selN, next_r.weN, next_r.refN} = pins(CMD_WRITE);
              OP_REFRESH:
                {next_r.selN, next_r.weN, next_r.refN} =
                  pins(CMD_REFRESH);
              default:
                {next_r.selN, next_r.weN, next_r.refN} = pins(CMD_NOP);
            endcase
            next_r.addr = userAddr;
            next_r.bank = userBank;
          end
        end
        default:
        begin
          next_r.st = ST_STABLE;
          next_r.cnt = `CNT_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      r.ck <= 1'b0;
      r.ckN <= 1'b1;
      r.st <= ST_STABLE;
      r.cnt <= `CNT_ZERO;
      r.selN <= 1'b1;
      r.weN <= 1'b1;
      r.refN <= 1'b1;
      r.addr <= '0;
      r.bank <= '0;
      r.done <= 1'b0;
    end
    else
      r <= next_r;
  end

  assign initDone = r.done;
  assign cmdClk = r.ck;
  assign cmdClkN = r.ckN;
  assign selectN = r.selN;
  assign writeEnN = r.weN;
  assign refreshN = r.refN;
  assign addr = r.addr;
  assign bank = r.bank;

endmodule

// ### init_seq_map.svh
// timing, counts and field constants of the power-up sequencer
`ifndef INIT_SEQ_MAP_SVH
`define INIT_SEQ_MAP_SVH
`define MCLK_PERIOD_PS   8000
`define STABLE_TIME_US   200
`define STABLE_CYC_W     14
// command clock is mclk/2, so one command cycle is two mclk periods
`define STABLE_CMD_CYC \
  ((`STABLE_TIME_US * 1000000 + 2 * `MCLK_PERIOD_PS - 1) \
   / (2 * `MCLK_PERIOD_PS))
`define DUMMY_LOADS      14'h0002
`define SETTLE_CYC       14'h0006
`define REFRESH_NOPS     14'h0400
`define BANK_COUNT       14'h0008
`define ADDR_W           20
`define BANK_W           3
`define MODE_W           10
`define CNT_ONE          14'h0001
`define CNT_ZERO         14'h0000
`endif

// ### init_seq_pkg.sv
// types of the power-up sequencer
package init_seq_pkg;
  typedef enum logic [2:0] {
    ST_STABLE  = 3'b000,
    ST_DUMMY   = 3'b001,
    ST_VALID   = 3'b010,
    ST_SETTLE  = 3'b011,
    ST_REFRESH = 3'b100,
    ST_READY   = 3'b101
  } state_t;

  typedef enum logic [2:0] {
    CMD_NOP     = 3'b000,
    CMD_LOAD    = 3'b001,
    CMD_REFRESH = 3'b010,
    CMD_READ    = 3'b011,
    CMD_WRITE   = 3'b100
  } cmd_t;

  typedef enum logic [1:0] {
    OP_READ    = 2'b00,
    OP_WRITE   = 2'b01,
    OP_REFRESH = 2'b10
  } op_t;
endpackage

// ### dram_init_ctrl_monitor.sv
// port checker for the power-up sequencer
`timescale 1ns/1ps
module dram_init_ctrl_monitor #(
  parameter logic [13:0] STABLE_CYC = 14'h0004
)(
  input logic        mclk,
  input logic        arst_n,
  input logic        userReq,
  input logic [1:0]  userOp,
  input logic [19:0] userAddr,
  input logic        userReady,
  input logic        initDone,
  input logic        cmdClk,
  input logic        cmdClkN,
  input logic        selectN,
  input logic        writeEnN,
  input logic        refreshN,
  input logic [19:0] addr
);
  wire [2:0] c = {selectN, writeEnN, refreshN};
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_clk_pair: assert property (cmdClkN != cmdClk)
    else $error("clock pair not complementary");
  a_clk_ratio: assert property (cmdClk |=> !cmdClk ##1 cmdClk)
    else $error("command clock not mclk/2");
  a_cmd_hold: assert property ($changed(c) |-> $fell(cmdClk))
    else $error("command changed off the falling edge");
  a_init_cmds: assert property (!initDone |-> c inside {7, 0, 2})
    else $error("stray command during init");
  a_user_gate: assert property (userReady |-> initDone && cmdClk)
    else $error("request accepted early");
  a_read_issue: assert property (userReq && userReady && userOp == 2'h0
    |=> c == 3'h3 && addr == $past(userAddr))
    else $error("read not issued");
  a_load_burst: assert property ($rose(c == 3'h0)
    |-> ##2 c == 3'h0 ##2 c == 3'h0 ##2 c != 3'h0)
    else $error("load burst not three back to back");
  a_settle_gap: assert property ($fell(c == 3'h0)
    |-> (c == 3'h7)[*8] ##1 (c == 3'h7)[*4] ##1 c == 3'h2)
    else $error("settle gap wrong");
  a_load_addr: assert property (c == 3'h0 |-> addr[19:10] == 10'h0)
    else $error("upper load address bits set");
  cover property ($rose(initDone));
  cover property ($rose(c == 3'h2));
  cover property (userReq && userReady && userOp == 2'h1);
endmodule
bind dram_init_ctrl dram_init_ctrl_monitor #(.STABLE_CYC(STABLE_CYC))
  i_dram_init_ctrl_monitor (.*);

// ### dram_dev_model.sv
// memory device model: logs every command seen at command clock rise
`timescale 1ns/1ps
module dram_dev_model (
  input logic        cmdClk,
  input logic        cmdClkN,
  input logic [2:0]  pins,
  input logic [19:0] addr,
  input logic [2:0]  bank
);
  logic [25:0] q[$];
  // takes loads and posted refreshes one per cycle, no settle inside
  always @(posedge cmdClk) q.push_back({pins, addr, bank});
endmodule

// ### dram_init_ctrl_tb.sv
// bench: sequencer command stream against an expected order
`timescale 1ns/1ps
module dram_init_ctrl_tb;
  localparam logic [25:0] P = 26'h3800000, PA = 26'h3FFFFF8;
  localparam logic [25:0] PB = 26'h3800007, ALL = 26'h3FFFFFF;
  logic        mclk, arst_n, userReq, userReady, initDone;
  logic        cmdClk, cmdClkN, selectN, writeEnN, refreshN;
  logic [1:0]  userOp;
  logic [9:0]  modeSetting;
  logic [19:0] userAddr, addr;
  logic [2:0]  userBank, bank;
  logic [25:0] e;
  logic [2:0]  opc [3] = '{3'h3, 3'h1, 3'h2};
  int          n_fail, checks_done, i;
  dram_init_ctrl #(.STABLE_CYC(14'h0004)) i_dram_init_ctrl (.*);
  dram_dev_model i_dram_dev_model (.cmdClk, .cmdClkN,
    .pins({selectN, writeEnN, refreshN}), .addr, .bank);
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    #100000;
    n_fail++;
    close_out();
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic pop(input bit skip);
    int n;
    n = 0;
    e = 'x;
    while (n < 9000)
      if (i_dram_dev_model.q.size() > 0)
      begin
        e = i_dram_dev_model.q.pop_front();
        if (!skip || e[25:23] != 3'h7)
          return;
      end
      else
      begin
        @(negedge mclk);
        n++;
      end
  endtask
  task automatic chk(input logic [25:0] x, m);
    checks_done++;
    if ((e & m) !== (x & m))
    begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, e, x);
    end
  endtask
  task automatic seq(input int n, input logic [25:0] x, m, s);
    repeat (n)
    begin
      pop(0);
      chk(x, m);
      x = x + s;
    end
  endtask
  // waits for readiness, then drops the request after one take
  task automatic issue(input logic [1:0] op);
    int n;
    n = 0;
    userOp = op;
    userReq = 1'b1;
    while (userReady !== 1'b1 && n < 5000)
    begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    userReq = 1'b0;
  endtask
  initial
  begin
    n_fail = 0;
    checks_done = 0;
    arst_n = 1'b0;
    userReq = 1'b0;
    userOp = 2'h0;
    void'($urandom(32'h48F7EEF5));
    modeSetting = 10'($urandom);
    userAddr = 20'($urandom);
    userBank = 3'($urandom);
    repeat (20) @(negedge mclk);
    arst_n = 1'b1;
    // read held from the start: must wait for the whole sequence
    issue(2'h0);
    // reset-state cycle plus STABLE_CYC counted cycles of no-operation
    seq(5, P, P, 0);
    seq(2, 0, PA, 0);
    seq(1, 26'({modeSetting, 3'h0}), PA, 0);
    seq(6, P, P, 0);
    seq(8, 26'h1000000, PB, 1);
    seq(1024, P, P, 0);
    pop(1);
    chk({3'h3, userAddr, userBank}, ALL);
    e = {25'h0, initDone};
    chk(26'h1, ALL);
    $display("init sequence test done");
    for (i = 0; i < 6; i++)
    begin
      userAddr = 20'($urandom);
      userBank = 3'($urandom);
      issue(2'(i % 3));
      pop(1);
      chk({opc[i % 3], userAddr, userBank}, i % 3 == 2 ? PB : ALL);
    end
    $display("user request test done");
    close_out();
  end
endmodule
